//--- rtl/power_ctrl_pkg.sv
package power_ctrl_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [9:0]  POWER_CONTROL_IDX   = 10'h087;
	localparam logic [9:0]  RESET_CAUSE_IDX     = 10'h0ef;
	localparam logic [9:0]  MODE_STATUS_IDX     = 10'h0f0;
	localparam logic [11:0] POWER_CONTROL_ADDR  = {POWER_CONTROL_IDX, 2'b00};
	localparam logic [11:0] RESET_CAUSE_ADDR    = {RESET_CAUSE_IDX, 2'b00};
	localparam logic [11:0] MODE_STATUS_ADDR    = {MODE_STATUS_IDX, 2'b00};
	localparam logic [7:0]  POWER_CONTROL_RESET = 8'h00;
	// field positions
	localparam int IDLE_SEL_BIT     = 0;
	localparam int HALT_SEL_BIT     = 1;
	localparam int FLAGS_LSB        = 2;
	localparam int POWER_ON_BIT     = 1;
	localparam int STATUS_MON_BIT   = 0;
	localparam int STATUS_MODE_LSB  = 4;
	// bus answers
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// timing
	localparam int CLK_PERIOD_NS       = 20;
	localparam int POR_DELAY_NS        = 300000;
	localparam int RESET_DELAY_NS      = 5000;
	localparam int POR_DELAY_CYCLES    = POR_DELAY_NS / CLK_PERIOD_NS;
	localparam int RESET_DELAY_CYCLES  = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WDT_CLOCK_DIV       = 12;
	localparam int CNT_W               = 14;

	typedef enum logic [2:0] {
		M_POWER_HOLD,
		M_POWER_DELAY,
		M_RESET,
		M_RELEASE,
		M_RUN,
		M_IDLE,
		M_STOP
	} mode_t;
endpackage : power_ctrl_pkg

//--- rtl/wdt_tick_gen.sv
`timescale 1ns/10ps
module wdt_tick_gen (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// control
	input  wire logic en,
	output logic      tick
);
	typedef struct packed {
		logic [3:0] cnt;
		logic       tick;
	} div_t;

	div_t cur;
	div_t next_cur;

	always_comb begin
		next_cur = cur;
		next_cur.tick = 1'b0;
		if (en) begin
			if (cur.cnt == 4'(power_ctrl_pkg::WDT_CLOCK_DIV - 1)) begin
				next_cur.cnt = 4'h0;
				next_cur.tick = 1'b1;
			end else begin
				next_cur.cnt = cur.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign tick = cur.tick;
endmodule : wdt_tick_gen

//--- rtl/axil_reg_slave.sv
`timescale 1ns/10ps
module axil_reg_slave (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// register side
	output logic             wr_en,
	output logic [11:0]      wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_ok,
	output logic             rd_en,
	output logic [11:0]      rd_addr,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_ok
);
	typedef struct packed {
		logic        aw_held;
		logic [11:0] aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} slave_t;

	slave_t cur;
	slave_t next_cur;

	assign s_axi_awready = !cur.aw_held && !cur.bvalid;
	assign s_axi_wready  = !cur.w_held && !cur.bvalid;
	assign s_axi_arready = !cur.rvalid;
	// both halves are latched first, so address and data may come in any order
	assign wr_en   = cur.aw_held && cur.w_held && !cur.bvalid;
	assign wr_addr = cur.aw_addr;
	assign wr_data = cur.w_data;
	assign wr_strb = cur.w_strb;
	assign rd_en   = s_axi_arvalid && !cur.rvalid;
	assign rd_addr = s_axi_araddr;

	always_comb begin
		next_cur = cur;
		if (s_axi_awvalid && s_axi_awready) begin
			next_cur.aw_held = 1'b1;
			next_cur.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_cur.w_held = 1'b1;
			next_cur.w_data = s_axi_wdata;
			next_cur.w_strb = s_axi_wstrb;
		end
		if (wr_en) begin
			next_cur.aw_held = 1'b0;
			next_cur.w_held = 1'b0;
			next_cur.bvalid = 1'b1;
			next_cur.bresp = wr_ok ? power_ctrl_pkg::RESP_OKAY : power_ctrl_pkg::RESP_SLVERR;
		end
		if (cur.bvalid && s_axi_bready) begin
			next_cur.bvalid = 1'b0;
		end
		if (rd_en) begin
			next_cur.rvalid = 1'b1;
			next_cur.rdata = rd_ok ? rd_data : 32'h0000_0000;
			next_cur.rresp = rd_ok ? power_ctrl_pkg::RESP_OKAY : power_ctrl_pkg::RESP_SLVERR;
		end else if (cur.rvalid && s_axi_rready) begin
			next_cur.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign s_axi_bvalid = cur.bvalid;
	assign s_axi_bresp  = cur.bresp;
	assign s_axi_rvalid = cur.rvalid;
	assign s_axi_rdata  = cur.rdata;
	assign s_axi_rresp  = cur.rresp;
endmodule : axil_reg_slave

//--- rtl/power_mode_and_reset_control.sv
// What this block does
// - setting idle select halts the core after the write; clocks and peripherals run on
// - idle keeps all register and memory contents unchanged
// - an enabled interrupt ends idle, idle select reads clear, core resumes
// - after the handler the core continues after the instruction that set idle
// - a reset during idle runs the normal reset sequence, fetch from zero
// - an unserviced enabled watchdog reset ends idle
// - setting halt select stops oscillator, core and digital peripherals after the write
// - halt-all ends only by reset, then normal sequence from address zero
// - reset halts execution, loads register defaults, forces ports, disables interrupts, timers
// - reset keeps data memory but reinitialises the stack pointer
// - in reset port latches are all ones open-drain; weak pullups stay on
// - power-on and supply-monitor resets drive the reset line low until exit
// - on exit clear PC, select internal oscillator, enable watchdog at clock/12
// - at power-up hold reset until supply is good, then add release delay
// - power-on flag set leaving power-on reset, cleared by every other reset
// - supply monitor off after power-on; other resets leave its state alone
// - enabled monitor holds reset and drives the line while supply is low
// - writing one to power-on flag enables monitor and resets, unless already enabled
`timescale 1ns/10ps
module power_mode_and_reset_control #(
	parameter int POR_DELAY_CYCLES = power_ctrl_pkg::POR_DELAY_CYCLES
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// register bus
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// reset sources and supply
	input  wire logic        supply_ok,
	input  wire logic        internal_reset_req,
	input  wire logic        rst_pin_in,
	output logic             rst_pin_out,
	output logic             rst_pin_oe_n,
	// core and system side
	input  wire logic        irq_wake,
	input  wire logic        clock_stable,
	output logic             core_halt,
	output logic             sys_reset,
	output logic             reset_exit,
	output logic             osc_stop,
	output logic             periph_stop,
	output logic             port_latch_ones,
	output logic             weak_pullup_en,
	output logic             wdt_tick,
	output logic             monitor_enable
);
	typedef struct packed {
		power_ctrl_pkg::mode_t            mode;
		logic [power_ctrl_pkg::CNT_W-1:0] cnt;
		logic [5:0]                       general_flags;
		logic                             power_on_flag;
		logic                             monitor_enable;
		logic                             pin_drive;
		logic                             reset_exit;
	} ctrl_t;

	ctrl_t cur;
	ctrl_t next_cur;

	logic        wr_en;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_ok;
	logic        rd_en;
	logic [11:0] rd_addr;
	logic [31:0] rd_data;
	logic        rd_ok;
	logic        in_reset;
	logic        mon_trip;
	logic        ext_src;
	logic        any_src;
	logic        power_control_wr;
	logic        cause_wr;

	axil_reg_slave u_bus (
		.clk           (clk),
		.rst           (rst),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_ok         (wr_ok),
		.rd_en         (rd_en),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_ok         (rd_ok)
	);

	// the divider stops with the oscillator in halt-all
	wdt_tick_gen u_wdt_div (
		.clk  (clk),
		.rst  (rst),
		.en   (cur.mode != power_ctrl_pkg::M_STOP),
		.tick (wdt_tick)
	);

	assign in_reset = (cur.mode == power_ctrl_pkg::M_POWER_HOLD) || (cur.mode == power_ctrl_pkg::M_POWER_DELAY)
		|| (cur.mode == power_ctrl_pkg::M_RESET) || (cur.mode == power_ctrl_pkg::M_RELEASE);
	assign mon_trip = cur.monitor_enable && !supply_ok;
	// our own low drive on the line must not look like an external reset
	assign ext_src  = !rst_pin_in && !cur.pin_drive;
	assign any_src  = ext_src || internal_reset_req || mon_trip;
	assign power_control_wr  = wr_en && wr_strb[0] && (wr_addr == power_ctrl_pkg::POWER_CONTROL_ADDR);
	assign cause_wr = wr_en && wr_strb[0] && (wr_addr == power_ctrl_pkg::RESET_CAUSE_ADDR);
	assign wr_ok    = (wr_addr == power_ctrl_pkg::POWER_CONTROL_ADDR) || (wr_addr == power_ctrl_pkg::RESET_CAUSE_ADDR)
		|| (wr_addr == power_ctrl_pkg::MODE_STATUS_ADDR);

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok = 1'b1;
		unique case (rd_addr)
			power_ctrl_pkg::POWER_CONTROL_ADDR: begin
				// select bits always read zero
				rd_data[power_ctrl_pkg::FLAGS_LSB +: 6] = cur.general_flags;
			end
			power_ctrl_pkg::RESET_CAUSE_ADDR: begin
				rd_data[power_ctrl_pkg::POWER_ON_BIT] = cur.power_on_flag;
			end
			power_ctrl_pkg::MODE_STATUS_ADDR: begin
				rd_data[power_ctrl_pkg::STATUS_MON_BIT] = cur.monitor_enable;
				rd_data[power_ctrl_pkg::STATUS_MODE_LSB +: 3] = cur.mode;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	always_comb begin
		next_cur = cur;
		next_cur.reset_exit = 1'b0;
		unique case (cur.mode)
			power_ctrl_pkg::M_POWER_HOLD: begin
				next_cur.pin_drive = 1'b1;
				next_cur.cnt = '0;
				if (supply_ok) begin
					next_cur.mode = power_ctrl_pkg::M_POWER_DELAY;
				end
			end
			power_ctrl_pkg::M_POWER_DELAY: begin
				if (!supply_ok) begin
					next_cur.mode = power_ctrl_pkg::M_POWER_HOLD;
				end else if (cur.cnt == power_ctrl_pkg::CNT_W'(POR_DELAY_CYCLES - 1)) begin
					next_cur.mode = power_ctrl_pkg::M_RELEASE;
					next_cur.cnt = '0;
					next_cur.power_on_flag = 1'b1;
				end else begin
					next_cur.cnt = cur.cnt + power_ctrl_pkg::CNT_W'(1);
				end
			end
			power_ctrl_pkg::M_RESET: begin
				next_cur.cnt = '0;
				if (mon_trip) begin
					next_cur.pin_drive = 1'b1;
				end
				if (!any_src) begin
					// monitor release skips the power-up delay
					next_cur.mode = power_ctrl_pkg::M_RELEASE;
				end
			end
			power_ctrl_pkg::M_RELEASE: begin
				if (any_src) begin
					next_cur.mode = power_ctrl_pkg::M_RESET;
					next_cur.power_on_flag = 1'b0;
					next_cur.pin_drive = cur.pin_drive || mon_trip;
				end else if (cur.cnt >= power_ctrl_pkg::CNT_W'(power_ctrl_pkg::RESET_DELAY_CYCLES - 1) && clock_stable) begin
					next_cur.mode = power_ctrl_pkg::M_RUN;
					next_cur.reset_exit = 1'b1;
					next_cur.pin_drive = 1'b0;
				end else if (cur.cnt < power_ctrl_pkg::CNT_W'(power_ctrl_pkg::RESET_DELAY_CYCLES - 1)) begin
					next_cur.cnt = cur.cnt + power_ctrl_pkg::CNT_W'(1);
				end
			end
			power_ctrl_pkg::M_RUN: begin
				if (power_control_wr) begin
					next_cur.general_flags = wr_data[power_ctrl_pkg::FLAGS_LSB +: 6];
					if (wr_data[power_ctrl_pkg::HALT_SEL_BIT]) begin
						next_cur.mode = power_ctrl_pkg::M_STOP;
					end else if (wr_data[power_ctrl_pkg::IDLE_SEL_BIT]) begin
						next_cur.mode = power_ctrl_pkg::M_IDLE;
					end
				end
				if (cause_wr && wr_data[power_ctrl_pkg::POWER_ON_BIT] && !cur.monitor_enable) begin
					next_cur.monitor_enable = 1'b1;
					next_cur.mode = power_ctrl_pkg::M_RESET;
				end
			end
			power_ctrl_pkg::M_IDLE: begin
				if (irq_wake) begin
					// no reset on wake, so the core carries on after the setting write
					next_cur.mode = power_ctrl_pkg::M_RUN;
				end
			end
			power_ctrl_pkg::M_STOP: begin
				// interrupts cannot wake halt-all; only the reset sources below
			end
		endcase
		// any reset source from run, idle or halt-all restarts the sequence
		if (any_src && ((cur.mode == power_ctrl_pkg::M_RUN) || (cur.mode == power_ctrl_pkg::M_IDLE)
			|| (cur.mode == power_ctrl_pkg::M_STOP))) begin
			next_cur.mode = power_ctrl_pkg::M_RESET;
		end
		// register defaults reload on every reset entry; monitor state is kept
		if (next_cur.mode == power_ctrl_pkg::M_RESET && cur.mode != power_ctrl_pkg::M_RESET) begin
			next_cur.general_flags = power_ctrl_pkg::POWER_CONTROL_RESET[power_ctrl_pkg::FLAGS_LSB +: 6];
			next_cur.power_on_flag = 1'b0;
			next_cur.pin_drive = cur.pin_drive || mon_trip;
			next_cur.cnt = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur.mode <= power_ctrl_pkg::M_POWER_HOLD;
			cur.cnt <= '0;
			cur.general_flags <= power_ctrl_pkg::POWER_CONTROL_RESET[power_ctrl_pkg::FLAGS_LSB +: 6];
			cur.power_on_flag <= 1'b0;
			cur.monitor_enable <= 1'b0;
			cur.pin_drive <= 1'b1;
			cur.reset_exit <= 1'b0;
		end else begin
			cur <= next_cur;
		end
	end

	// core, memories and peripherals are simply frozen, not cleared
	assign core_halt       = (cur.mode != power_ctrl_pkg::M_RUN);
	assign sys_reset       = in_reset;
	assign reset_exit      = cur.reset_exit;
	assign osc_stop        = (cur.mode == power_ctrl_pkg::M_STOP);
	assign periph_stop     = (cur.mode == power_ctrl_pkg::M_STOP);
	assign port_latch_ones = in_reset;
	assign weak_pullup_en  = 1'b1;
	assign rst_pin_out     = 1'b0;
	assign rst_pin_oe_n    = !cur.pin_drive;
	assign monitor_enable  = cur.monitor_enable;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence leave_reset_s;
		(cur.mode == power_ctrl_pkg::M_RELEASE) ##1 (cur.mode == power_ctrl_pkg::M_RUN);
	endsequence

	sequence leave_power_on_s;
		(cur.mode == power_ctrl_pkg::M_POWER_DELAY) ##1 (cur.mode == power_ctrl_pkg::M_RELEASE);
	endsequence

	idle_entry_a: assert property ((cur.mode == power_ctrl_pkg::M_RUN) && power_control_wr && !any_src
		&& wr_data[0] && !wr_data[1] |=> core_halt && !osc_stop && (cur.mode == power_ctrl_pkg::M_IDLE))
		else $error("idle select did not halt the core");
	idle_keeps_a: assert property ((cur.mode == power_ctrl_pkg::M_IDLE) && !irq_wake && !any_src
		|=> $stable(cur.general_flags) && (cur.mode == power_ctrl_pkg::M_IDLE))
		else $error("state changed during idle");
	idle_wake_a: assert property ((cur.mode == power_ctrl_pkg::M_IDLE) && irq_wake && !any_src
		|=> !core_halt ##0 (cur.mode == power_ctrl_pkg::M_RUN))
		else $error("interrupt did not wake from idle");
	idle_reset_a: assert property ((cur.mode == power_ctrl_pkg::M_IDLE) && internal_reset_req
		|=> cur.mode == power_ctrl_pkg::M_RESET)
		else $error("watchdog reset did not end idle");
	stop_entry_a: assert property ((cur.mode == power_ctrl_pkg::M_RUN) && power_control_wr && wr_data[1] && !any_src
		|=> osc_stop && periph_stop && core_halt)
		else $error("halt select did not stop the clocks");
	stop_hold_a: assert property ((cur.mode == power_ctrl_pkg::M_STOP) && !any_src
		|=> cur.mode == power_ctrl_pkg::M_STOP)
		else $error("halt-all left without a reset");
	select_read_a: assert property (rd_en && (rd_addr == power_ctrl_pkg::POWER_CONTROL_ADDR)
		|=> s_axi_rdata[1:0] == 2'b00)
		else $error("select bits did not read zero");
	reset_state_a: assert property ((cur.mode == power_ctrl_pkg::M_RESET)
		|-> sys_reset && core_halt && port_latch_ones && weak_pullup_en && (cur.general_flags == 6'h00))
		else $error("reset outputs wrong");
	exit_pulse_a: assert property (leave_reset_s |-> reset_exit ##1 !reset_exit)
		else $error("reset exit pulse missing");
	por_delay_a: assert property (leave_power_on_s
		|-> $past(cur.cnt, 1) == power_ctrl_pkg::CNT_W'(POR_DELAY_CYCLES - 1) && !rst_pin_oe_n)
		else $error("power-up delay wrong");
	por_flag_a: assert property (leave_power_on_s |-> cur.power_on_flag)
		else $error("power-on flag not set");
	flag_clear_a: assert property ($rose(cur.mode == power_ctrl_pkg::M_RESET) |-> !cur.power_on_flag)
		else $error("power-on flag kept over a reset");
	monitor_keep_a: assert property ((cur.mode != power_ctrl_pkg::M_RUN) |=> $stable(cur.monitor_enable))
		else $error("monitor state changed by reset");
	monitor_trip_a: assert property (mon_trip && (cur.mode != power_ctrl_pkg::M_POWER_HOLD)
		|=> !rst_pin_oe_n && sys_reset)
		else $error("monitor trip did not hold reset");
	monitor_write_a: assert property ((cur.mode == power_ctrl_pkg::M_RUN) && cause_wr && wr_data[1]
		&& !cur.monitor_enable |=> cur.monitor_enable && (cur.mode == power_ctrl_pkg::M_RESET))
		else $error("monitor enable did not reset");
endmodule : power_mode_and_reset_control

//--- tb/supply_reset_model.sv
`timescale 1ns/10ps
module supply_reset_model (
	// commands from the bench
	input  wire logic supply_good,
	input  wire logic ext_reset,
	// device side
	input  wire logic rst_pin_out,
	input  wire logic rst_pin_oe_n,
	output logic      supply_ok,
	output logic      rst_pin_in
);
	// supply comparator seen as a clean level; ramp shape is not modelled
	assign supply_ok = supply_good;
	// line has a pull-up, so a released line reads high, never the last driven value
	assign rst_pin_in = ((!rst_pin_oe_n && !rst_pin_out) || ext_reset) ? 1'b0 : 1'b1;
endmodule : supply_reset_model

//--- tb/power_mode_and_reset_control_tb.sv
`timescale 1ns/10ps
module power_mode_and_reset_control_tb;
	localparam int          POR_CYC = 20;
	localparam logic [11:0] PC_A    = power_ctrl_pkg::POWER_CONTROL_ADDR;
	localparam logic [11:0] RC_A    = power_ctrl_pkg::RESET_CAUSE_ADDR;
	localparam logic [11:0] MS_A    = power_ctrl_pkg::MODE_STATUS_ADDR;
	logic        clk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, internal_reset_req = 1'b0, irq_wake = 1'b0;
	logic        clock_stable = 1'b1, supply_good = 1'b0, ext_reset = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, supply_ok, rst_pin_in;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, rd;
	logic        rst_pin_out, rst_pin_oe_n, core_halt, sys_reset, reset_exit, osc_stop, periph_stop;
	logic        port_latch_ones, weak_pullup_en, wdt_tick, monitor_enable;
	int          errors = 0, tests_run = 0, n, p;

	power_mode_and_reset_control #(.POR_DELAY_CYCLES(POR_CYC)) u_power_mode_and_reset_control (
		.clk(clk), .rst(rst),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.supply_ok(supply_ok), .internal_reset_req(internal_reset_req), .rst_pin_in(rst_pin_in),
		.rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .irq_wake(irq_wake),
		.clock_stable(clock_stable), .core_halt(core_halt), .sys_reset(sys_reset),
		.reset_exit(reset_exit), .osc_stop(osc_stop), .periph_stop(periph_stop),
		.port_latch_ones(port_latch_ones), .weak_pullup_en(weak_pullup_en), .wdt_tick(wdt_tick),
		.monitor_enable(monitor_enable)
	);
	supply_reset_model u_supply_reset_model (
		.supply_good(supply_good), .ext_reset(ext_reset), .rst_pin_out(rst_pin_out),
		.rst_pin_oe_n(rst_pin_oe_n), .supply_ok(supply_ok), .rst_pin_in(rst_pin_in)
	);

	always #10 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_done = 0;
		bit w_done = 0;
		int k = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_done && w_done) && k < 100) begin
			@(posedge clk);
			k++;
			if (!aw_done && s_axi_awready) begin
				aw_done = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready) begin
				w_done = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		// bready rises at the taking edge, in the same step where the last valid fell
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (!s_axi_bvalid && k < 200);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int k = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (!s_axi_arready && k < 100);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (!s_axi_rvalid && k < 200);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_read

	// cycles until the core runs, and how many exit pulses were seen around it
	task automatic wait_run(output int c, output int pulses);
		c = 0;
		pulses = 0;
		do begin
			@(posedge clk);
			c++;
			pulses += int'(reset_exit === 1'b1);
		end while (core_halt !== 1'b0 && c < 3000);
		repeat (2) begin
			@(posedge clk);
			pulses += int'(reset_exit === 1'b1);
		end
	endtask : wait_run

	task automatic t_power_up;
		repeat (10) @(posedge clk);
		check(rst_pin_oe_n, 1'h0);
		check(rst_pin_out, 1'h0);
		check(core_halt, 1'h1);
		check(port_latch_ones, 1'h1);
		check(sys_reset, 1'h1);
		supply_good <= 1'b1;
		wait_run(n, p);
		check(n >= POR_CYC + 250, 1'h1);
		check(p, 32'h0000_0001);
		check(rst_pin_oe_n, 1'h1);
		check(weak_pullup_en, 1'h1);
		axi_read(RC_A, rd, resp);
		check(rd[1], 1'h1);
		axi_read(MS_A, rd, resp);
		check(rd[0], 1'h0);
	endtask : t_power_up

	task automatic t_regs;
		axi_read(PC_A, rd, resp);
		check(rd, 32'h0000_0000);
		axi_write(PC_A, 32'h0000_00fc, resp);
		check(resp, power_ctrl_pkg::RESP_OKAY);
		axi_read(PC_A, rd, resp);
		check(rd, 32'h0000_00fc);
		axi_read(12'h004, rd, resp);
		check(resp, power_ctrl_pkg::RESP_SLVERR);
		check(rd, 32'h0000_0000);
		axi_write(12'h004, 32'h0000_00ff, resp);
		check(resp, power_ctrl_pkg::RESP_SLVERR);
	endtask : t_regs

	task automatic t_idle;
		axi_write(PC_A, 32'h0000_00fd, resp);
		@(posedge clk);
		check(core_halt, 1'h1);
		check(osc_stop | periph_stop, 1'h0);
		do @(posedge clk); while (wdt_tick !== 1'b1);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wdt_tick !== 1'b1 && n < 50);
		check(n, 32'h0000_000c);
		axi_read(PC_A, rd, resp);
		check(rd, 32'h0000_00fc);
		irq_wake <= 1'b1;
		repeat (2) @(posedge clk);
		check(core_halt, 1'h0);
		irq_wake <= 1'b0;
		axi_read(PC_A, rd, resp);
		check(rd, 32'h0000_00fc);
	endtask : t_idle

	task automatic t_monitor;
		axi_write(RC_A, 32'h0000_0002, resp);
		@(posedge clk);
		check(sys_reset, 1'h1);
		check(monitor_enable, 1'h1);
		wait_run(n, p);
		check(p, 32'h0000_0001);
		axi_read(RC_A, rd, resp);
		check(rd[1], 1'h0);
		axi_write(RC_A, 32'h0000_0002, resp);
		repeat (5) @(posedge clk);
		check(sys_reset | core_halt, 1'h0);
		supply_good <= 1'b0;
		repeat (3) @(posedge clk);
		check(sys_reset, 1'h1);
		check(rst_pin_oe_n, 1'h0);
		supply_good <= 1'b1;
		wait_run(n, p);
		check(n >= 250 && n < 250 + POR_CYC, 1'h1);
		check(monitor_enable, 1'h1);
	endtask : t_monitor

	task automatic t_idle_reset;
		// flags set before the reset so the default reload is visible
		axi_write(PC_A, 32'h0000_00fd, resp);
		internal_reset_req <= 1'b1;
		repeat (2) @(posedge clk);
		check(sys_reset, 1'h1);
		check(rst_pin_oe_n, 1'h1);
		repeat (5) @(posedge clk);
		internal_reset_req <= 1'b0;
		clock_stable <= 1'b0;
		repeat (300) @(posedge clk);
		check(core_halt, 1'h1);
		clock_stable <= 1'b1;
		wait_run(n, p);
		check(n < 3, 1'h1);
		check(p, 32'h0000_0001);
		check(monitor_enable, 1'h1);
		axi_read(PC_A, rd, resp);
		check(rd, 32'h0000_0000);
	endtask : t_idle_reset

	task automatic t_stop;
		// internal reset request stays low: lost-clock detector treated as disabled
		axi_write(PC_A, 32'h0000_0002, resp);
		@(posedge clk);
		check(osc_stop & periph_stop & core_halt, 1'h1);
		irq_wake <= 1'b1;
		n = 0;
		repeat (30) begin
			@(posedge clk);
			n += int'(wdt_tick === 1'b1);
		end
		check(n, 32'h0000_0000);
		check(core_halt, 1'h1);
		irq_wake <= 1'b0;
		ext_reset <= 1'b1;
		repeat (3) @(posedge clk);
		check(sys_reset, 1'h1);
		ext_reset <= 1'b0;
		wait_run(n, p);
		check(p, 32'h0000_0001);
		check(osc_stop, 1'h0);
	endtask : t_stop

	task automatic print_verdict;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_power_up;
		t_regs;
		t_idle;
		t_monitor;
		t_idle_reset;
		t_stop;
		print_verdict;
	end

	// all scenarios need well under two thousand cycles; this 20000-cycle limit is over ten times that
	initial begin
		#400000;
		errors++;
		print_verdict;
	end
endmodule : power_mode_and_reset_control_tb
